//--- logic/cmbo_core.sv
// Core sequencer for register/memory and jump/branch instructions
`timescale 1ns/1ps
module cmbo_core (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] memRdata,
	input wire logic irqPin,
	input wire logic intMask,
	output cmbo_pkg::cmbo_mem_req_t memReq,
	output logic [15:0] pcOut,
	output logic [7:0] accOut,
	output logic [7:0] idxOut,
	output cmbo_pkg::cmbo_ccr_t ccrOut
);
	cmbo_pkg::cmbo_state_t state_reg, state_next;
	cmbo_pkg::cmbo_ccr_t ccr_reg;
	cmbo_pkg::cmbo_alu_out_t aluOut;
	logic [15:0] pc_reg, target_reg, ret_reg;
	logic [7:0] op_reg, byte1_reg, acc_reg, idx_reg, sp_reg;
	logic bitTaken_reg;
	logic isRel, isBitBr, isRegMem, isMul, isJmp, isJsr, isBsr, isStore;
	logic relTaken, bitVal;
	logic [15:0] nextSeq, relDest, product;

	// ****************************************
	// Decode
	// ****************************************
	assign isRel = op_reg[7:4] == cmbo_pkg::OPG_REL_BRANCH;
	assign isBitBr = op_reg[7:4] == cmbo_pkg::OPG_BIT_BRANCH;
	assign isRegMem = op_reg[7:4] == cmbo_pkg::OPG_REG_MEM;
	assign isMul = op_reg == cmbo_pkg::OP_MULTIPLY;
	assign isJmp = op_reg == cmbo_pkg::OP_UNCOND_JUMP;
	assign isJsr = op_reg == cmbo_pkg::OP_JUMP_SUB;
	assign isBsr = op_reg == cmbo_pkg::OP_BRANCH_SUB;
	assign isStore = isRegMem && (op_reg[3:0] == cmbo_pkg::RM_STORE_ACC
		|| op_reg[3:0] == cmbo_pkg::RM_STORE_IDX);
	// Bit number in bits 3..1, bit 0 set means branch when clear
	assign bitVal = memRdata[op_reg[3:1]];
	assign nextSeq = pc_reg + cmbo_pkg::PC_STEP;
	// Sign extension gives the -128..+127 reach past the offset byte
	assign relDest = nextSeq + {{8{memRdata[7]}}, memRdata};
	assign product = {8'h00, idx_reg} * {8'h00, acc_reg};

	always_comb
	begin
		case (op_reg[3:0])
			4'h0: relTaken = 1'b1;
			4'h1: relTaken = 1'b0;
			4'h2: relTaken = !(ccr_reg.c | ccr_reg.z);
			4'h3: relTaken = ccr_reg.c | ccr_reg.z;
			4'h4: relTaken = !ccr_reg.c;
			4'h5: relTaken = ccr_reg.c;
			4'h6: relTaken = !ccr_reg.z;
			4'h7: relTaken = ccr_reg.z;
			4'h8: relTaken = !ccr_reg.h;
			4'h9: relTaken = ccr_reg.h;
			4'hA: relTaken = !ccr_reg.n;
			4'hB: relTaken = ccr_reg.n;
			4'hC: relTaken = !intMask;
			4'hD: relTaken = intMask;
			4'hE: relTaken = !irqPin;
			default: relTaken = irqPin;
		endcase
	end

	cmbo_alu u_alu (
		.subOp(op_reg[3:0]),
		.acc(acc_reg),
		.idx(idx_reg),
		.mem(memRdata),
		.carryIn(ccr_reg.c),
		.out(aluOut)
	);

	// ****************************************
	// Memory request
	// ****************************************
	always_comb
	begin
		memReq.addr = pc_reg;
		memReq.wdata = acc_reg;
		memReq.we = 1'b0;
		case (state_reg)
			cmbo_pkg::S_MEM:
			begin
				// Direct operands live in the first page only
				memReq.addr = {cmbo_pkg::DIRECT_PAGE, byte1_reg};
				memReq.we = isStore;
				memReq.wdata = (op_reg[3:0] == cmbo_pkg::RM_STORE_IDX) ? idx_reg : acc_reg;
			end
			cmbo_pkg::S_PUSH_LO:
			begin
				memReq.addr = {cmbo_pkg::DIRECT_PAGE, sp_reg};
				memReq.wdata = ret_reg[7:0];
				memReq.we = 1'b1;
			end
			cmbo_pkg::S_PUSH_HI:
			begin
				memReq.addr = {cmbo_pkg::DIRECT_PAGE, sp_reg};
				memReq.wdata = ret_reg[15:8];
				memReq.we = 1'b1;
			end
			default: memReq.addr = pc_reg;
		endcase
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		case (state_reg)
			cmbo_pkg::S_FETCH: state_next = cmbo_pkg::S_OPER1;
			cmbo_pkg::S_OPER1:
			begin
				if (isRegMem || isBitBr)
					state_next = cmbo_pkg::S_MEM;
				else if (isJmp || isJsr)
					state_next = cmbo_pkg::S_OPER2;
				else if (isBsr)
					state_next = cmbo_pkg::S_PUSH_LO;
				else
					state_next = cmbo_pkg::S_FETCH;
			end
			cmbo_pkg::S_MEM: state_next = isBitBr ? cmbo_pkg::S_OPER2 : cmbo_pkg::S_FETCH;
			cmbo_pkg::S_OPER2: state_next = isJsr ? cmbo_pkg::S_PUSH_LO : cmbo_pkg::S_FETCH;
			cmbo_pkg::S_PUSH_LO: state_next = cmbo_pkg::S_PUSH_HI;
			default: state_next = cmbo_pkg::S_FETCH;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			state_reg <= cmbo_pkg::S_FETCH;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_reg <= 8'h00;
			byte1_reg <= 8'h00;
			bitTaken_reg <= 1'b0;
		end
		else
		begin
			if (state_reg == cmbo_pkg::S_FETCH)
				op_reg <= memRdata;
			if (state_reg == cmbo_pkg::S_OPER1)
				byte1_reg <= memRdata;
			if (state_reg == cmbo_pkg::S_MEM)
				bitTaken_reg <= bitVal != op_reg[0];
		end
	end

	// ****************************************
	// Program counter and call state
	// ****************************************
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			pc_reg <= cmbo_pkg::PC_RESET;
		else if (state_reg == cmbo_pkg::S_FETCH)
			pc_reg <= nextSeq;
		else if (state_reg == cmbo_pkg::S_OPER1)
		begin
			if (isRel && relTaken)
				pc_reg <= relDest;
			else if (isRel || isBitBr || isRegMem || isJmp || isJsr || isBsr)
				pc_reg <= nextSeq;
		end
		else if (state_reg == cmbo_pkg::S_OPER2)
		begin
			if (isJmp)
				pc_reg <= {byte1_reg, memRdata};
			else if (isBitBr && bitTaken_reg)
				pc_reg <= relDest;
			else
				pc_reg <= nextSeq;
		end
		else if (state_reg == cmbo_pkg::S_PUSH_HI)
			pc_reg <= target_reg;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			target_reg <= cmbo_pkg::PC_RESET;
			ret_reg <= cmbo_pkg::PC_RESET;
		end
		else if ((state_reg == cmbo_pkg::S_OPER1 && isBsr)
			|| (state_reg == cmbo_pkg::S_OPER2 && isJsr))
		begin
			target_reg <= isBsr ? relDest : {byte1_reg, memRdata};
			ret_reg <= nextSeq;
		end
	end

	// Stack grows down inside the first page; no overflow guard
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			sp_reg <= cmbo_pkg::SP_RESET;
		else if (state_reg == cmbo_pkg::S_PUSH_LO || state_reg == cmbo_pkg::S_PUSH_HI)
			sp_reg <= sp_reg - 8'h01;
	end

	// ****************************************
	// Registers and flags
	// ****************************************
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_reg <= 8'h00;
			idx_reg <= 8'h00;
			ccr_reg <= '0;
		end
		else if (state_reg == cmbo_pkg::S_OPER1 && isMul)
		begin
			{idx_reg, acc_reg} <= product;
			ccr_reg.h <= 1'b0;
			ccr_reg.c <= 1'b0;
		end
		else if (state_reg == cmbo_pkg::S_MEM && isBitBr)
			ccr_reg.c <= bitVal;
		else if (state_reg == cmbo_pkg::S_MEM && isRegMem)
		begin
			if (aluOut.wrAcc)
				acc_reg <= aluOut.res;
			if (aluOut.wrIdx)
				idx_reg <= aluOut.res;
			if (aluOut.updNZ)
			begin
				ccr_reg.n <= aluOut.res[7];
				ccr_reg.z <= aluOut.res == 8'h00;
			end
			if (aluOut.updC)
				ccr_reg.c <= aluOut.c;
			if (aluOut.updH)
				ccr_reg.h <= aluOut.h;
		end
	end

	assign pcOut = pc_reg;
	assign accOut = acc_reg;
	assign idxOut = idx_reg;
	assign ccrOut = ccr_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence bitBranchSeq;
		state_reg == cmbo_pkg::S_OPER1 ##1 state_reg == cmbo_pkg::S_MEM
			##1 state_reg == cmbo_pkg::S_OPER2 ##1 state_reg == cmbo_pkg::S_FETCH;
	endsequence
	sequence pushSeq;
		state_reg == cmbo_pkg::S_PUSH_LO && memReq.we
			##1 state_reg == cmbo_pkg::S_PUSH_HI && memReq.we ##1 state_reg == cmbo_pkg::S_FETCH;
	endsequence

	operand_page_a: assert property (state_reg == cmbo_pkg::S_MEM |-> memReq.addr[15:8] == 8'h00 && memReq.addr[7:0] == byte1_reg) else $error("operand outside first page");
	add_result_a: assert property (state_reg == cmbo_pkg::S_MEM && isRegMem && op_reg[3:0] == cmbo_pkg::RM_ADD |=> acc_reg == $past(acc_reg) + $past(memRdata)) else $error("add result wrong");
	store_data_a: assert property (state_reg == cmbo_pkg::S_MEM && isRegMem && op_reg[3:0] == cmbo_pkg::RM_STORE_ACC |-> memReq.we && memReq.wdata == acc_reg) else $error("store write wrong");
	compare_keep_a: assert property (state_reg == cmbo_pkg::S_MEM && isRegMem && op_reg[3:0] == cmbo_pkg::RM_CMP_IDX |=> $stable(acc_reg) && $stable(idx_reg) && ccr_reg.z == ($past(idx_reg) == $past(memRdata))) else $error("compare altered register");
	jump_target_a: assert property (state_reg == cmbo_pkg::S_OPER2 && isJmp |=> pc_reg == {$past(byte1_reg), $past(memRdata)} && state_reg == cmbo_pkg::S_FETCH) else $error("jump target wrong");
	branch_skip_a: assert property (state_reg == cmbo_pkg::S_OPER1 && isRel && !relTaken |=> pc_reg == $past(pc_reg) + 16'h0001) else $error("untaken branch moved");
	branch_reach_a: assert property (state_reg == cmbo_pkg::S_OPER1 && isRel && relTaken |=> pc_reg == $past(pc_reg) + 16'h0001 + {{8{$past(memRdata[7])}}, $past(memRdata)}) else $error("branch target wrong");
	bit_length_a: assert property (state_reg == cmbo_pkg::S_FETCH && memRdata[7:4] == cmbo_pkg::OPG_BIT_BRANCH |=> bitBranchSeq) else $error("bit branch length wrong");
	bit_carry_a: assert property (state_reg == cmbo_pkg::S_MEM && isBitBr |=> ccr_reg.c == $past(bitVal) ##1 pc_reg == ($past(bitVal, 2) != op_reg[0] ? $past(relDest) : $past(pc_reg) + 16'h0001)) else $error("bit branch result wrong");
	call_push_a: assert property (state_reg == cmbo_pkg::S_OPER2 && isJsr |=> pushSeq) else $error("call push order wrong");
endmodule

//--- logic/cmbo_pkg.sv
// Package of encodings, reset values and carriers for the core
package cmbo_pkg;
	// ****************************************
	// Opcode groups and single opcodes
	// ****************************************
	localparam logic [3:0] OPG_BIT_BRANCH = 4'h0;
	localparam logic [3:0] OPG_REL_BRANCH = 4'h2;
	localparam logic [3:0] OPG_REG_MEM = 4'hB;
	localparam logic [7:0] OP_MULTIPLY = 8'h40;
	localparam logic [7:0] OP_UNCOND_JUMP = 8'hC0;
	localparam logic [7:0] OP_JUMP_SUB = 8'hC1;
	localparam logic [7:0] OP_BRANCH_SUB = 8'hC2;
	// ****************************************
	// Register/memory sub-operations (low nibble)
	// ****************************************
	localparam logic [3:0] RM_ADD = 4'h0;
	localparam logic [3:0] RM_ADD_CARRY = 4'h1;
	localparam logic [3:0] RM_SUB = 4'h2;
	localparam logic [3:0] RM_SUB_BORROW = 4'h3;
	localparam logic [3:0] RM_AND = 4'h4;
	localparam logic [3:0] RM_OR = 4'h5;
	localparam logic [3:0] RM_XOR = 4'h6;
	localparam logic [3:0] RM_BIT_TEST = 4'h7;
	localparam logic [3:0] RM_CMP_ACC = 4'h8;
	localparam logic [3:0] RM_CMP_IDX = 4'h9;
	localparam logic [3:0] RM_LOAD_ACC = 4'hA;
	localparam logic [3:0] RM_LOAD_IDX = 4'hB;
	localparam logic [3:0] RM_STORE_ACC = 4'hC;
	localparam logic [3:0] RM_STORE_IDX = 4'hD;
	// ****************************************
	// Reset values and sizes
	// ****************************************
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'hFF;
	localparam logic [7:0] DIRECT_PAGE = 8'h00;
	localparam logic [15:0] PC_STEP = 16'h0001;
	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [2:0] {
		S_FETCH = 3'b000,
		S_OPER1 = 3'b001,
		S_MEM = 3'b010,
		S_OPER2 = 3'b011,
		S_PUSH_LO = 3'b100,
		S_PUSH_HI = 3'b101
	} cmbo_state_t;
	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic c;
	} cmbo_ccr_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
	} cmbo_mem_req_t;
	typedef struct packed {
		logic [7:0] res;
		logic h;
		logic c;
		logic updH;
		logic updC;
		logic updNZ;
		logic wrAcc;
		logic wrIdx;
	} cmbo_alu_out_t;
endpackage

//--- logic/cmbo_alu.sv
// Arithmetic and logic unit for register/memory operations
`timescale 1ns/1ps
module cmbo_alu (
	input wire logic [3:0] subOp,
	input wire logic [7:0] acc,
	input wire logic [7:0] idx,
	input wire logic [7:0] mem,
	input wire logic carryIn,
	output cmbo_pkg::cmbo_alu_out_t out
);
	logic [8:0] sum;
	logic [8:0] diff;
	logic [7:0] regOpnd;
	logic useCarry;

	always_comb
	begin
		useCarry = (subOp == cmbo_pkg::RM_ADD_CARRY) || (subOp == cmbo_pkg::RM_SUB_BORROW);
		regOpnd = (subOp == cmbo_pkg::RM_CMP_IDX) ? idx : acc;
		sum = {1'b0, acc} + {1'b0, mem} + {8'h00, useCarry & carryIn};
		diff = {1'b0, regOpnd} - {1'b0, mem} - {8'h00, useCarry & carryIn};
	end

	always_comb
	begin
		out = '0;
		out.updNZ = 1'b1;
		case (subOp)
			cmbo_pkg::RM_ADD, cmbo_pkg::RM_ADD_CARRY:
			begin
				out.res = sum[7:0];
				out.c = sum[8];
				out.h = acc[4] ^ mem[4] ^ sum[4];
				out.updC = 1'b1;
				out.updH = 1'b1;
				out.wrAcc = 1'b1;
			end
			cmbo_pkg::RM_SUB, cmbo_pkg::RM_SUB_BORROW, cmbo_pkg::RM_CMP_ACC,
			cmbo_pkg::RM_CMP_IDX:
			begin
				out.res = diff[7:0];
				out.c = diff[8];
				out.updC = 1'b1;
				// Compares only touch flags
				out.wrAcc = (subOp == cmbo_pkg::RM_SUB) || (subOp == cmbo_pkg::RM_SUB_BORROW);
			end
			cmbo_pkg::RM_AND, cmbo_pkg::RM_BIT_TEST:
			begin
				out.res = acc & mem;
				out.wrAcc = (subOp == cmbo_pkg::RM_AND);
			end
			cmbo_pkg::RM_OR:
			begin
				out.res = acc | mem;
				out.wrAcc = 1'b1;
			end
			cmbo_pkg::RM_XOR:
			begin
				out.res = acc ^ mem;
				out.wrAcc = 1'b1;
			end
			cmbo_pkg::RM_LOAD_ACC:
			begin
				out.res = mem;
				out.wrAcc = 1'b1;
			end
			cmbo_pkg::RM_LOAD_IDX:
			begin
				out.res = mem;
				out.wrIdx = 1'b1;
			end
			cmbo_pkg::RM_STORE_ACC: out.res = acc;
			cmbo_pkg::RM_STORE_IDX: out.res = idx;
			default: out.updNZ = 1'b0;
		endcase
	end
endmodule

//--- sim/cmbo_mem_model.sv
// Behavioural program and data memory seen by the core
`timescale 1ns/1ps
module cmbo_mem_model (
	input wire logic mclk,
	input cmbo_pkg::cmbo_mem_req_t req,
	output logic [7:0] rdata
);
	// No wait states: the core has no stall input, so reads are combinational
	logic [7:0] cells [0:65535];
	assign rdata = cells[req.addr];
	always @(posedge mclk)
	begin
		if (req.we)
			cells[req.addr] <= req.wdata;
	end
endmodule

//--- sim/tb.sv
// Self-checking bench: random instruction stream against a reference model
`timescale 1ns/1ps
module tb;
	localparam int DLY = 2;
	logic mclk;
	logic resetn;
	logic irqPin;
	logic intMask;
	logic [7:0] memRdata;
	cmbo_pkg::cmbo_mem_req_t memReq;
	logic [15:0] pcOut;
	logic [7:0] accOut;
	logic [7:0] idxOut;
	cmbo_pkg::cmbo_ccr_t ccrOut;
	int miscompares;
	int nTests;
	logic [15:0] ePc;
	logic [7:0] eAcc;
	logic [7:0] eIdx;
	logic [7:0] eSp;
	cmbo_pkg::cmbo_ccr_t eCcr;

	cmbo_core uut (
		.mclk(mclk),
		.resetn(resetn),
		.memRdata(memRdata),
		.irqPin(irqPin),
		.intMask(intMask),
		.memReq(memReq),
		.pcOut(pcOut),
		.accOut(accOut),
		.idxOut(idxOut),
		.ccrOut(ccrOut)
	);
	cmbo_mem_model memModel (.mclk(mclk), .req(memReq), .rdata(memRdata));

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic tallyAndFinish();
		$display("comparisons %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic fail(input string msg);
		miscompares++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
		nTests++;
		if (got !== exp)
			fail($sformatf("%s got %h exp %h", what, got, exp));
	endtask

	task automatic chkPc(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp)
			fail($sformatf("pc got %h exp %h", got, exp));
	endtask

	task automatic chkCcr(input cmbo_pkg::cmbo_ccr_t got, input cmbo_pkg::cmbo_ccr_t exp);
		nTests++;
		if (got !== exp)
			fail($sformatf("flags got %b exp %b", got, exp));
	endtask

	task automatic cmpAll();
		chkPc(pcOut, ePc);
		chkByte(accOut, eAcc, "acc");
		chkByte(idxOut, eIdx, "idx");
		chkCcr(ccrOut, eCcr);
	endtask

	// Waits out the fixed cycle count of one instruction, then compares
	task automatic runChk(input int n);
		repeat (n) @(posedge mclk);
		#DLY;
		cmpAll();
	endtask

	task automatic put(input logic [15:0] a, input logic [7:0] v);
		memModel.cells[a] = v;
	endtask

	task automatic rstExpect();
		ePc = cmbo_pkg::PC_RESET;
		eAcc = 8'h00;
		eIdx = 8'h00;
		eSp = cmbo_pkg::SP_RESET;
		eCcr = 4'h0;
	endtask

	// Return address goes low byte first at the stack pointer, high byte below it
	task automatic pushChk(input logic [15:0] ret);
		chkByte(memModel.cells[{8'h00, eSp}], ret[7:0], "ret lo");
		chkByte(memModel.cells[{8'h00, eSp - 8'h01}], ret[15:8], "ret hi");
		eSp = eSp - 8'h02;
	endtask

	function automatic logic [15:0] rel(input logic [15:0] base, input logic [7:0] off);
		return base + {{8{off[7]}}, off};
	endfunction

	// Reach limits come up often so both ends of the span are hit
	function automatic logic [7:0] randOff();
		case ($urandom_range(0, 5))
		0: return 8'h80;
		1: return 8'h7F;
		default: return 8'($urandom);
		endcase
	endfunction

	function automatic logic relTaken(input logic [3:0] cc);
		logic t;
		case (cc[3:1])
		3'h0: t = 1'b1;
		3'h1: t = ~(eCcr.c | eCcr.z);
		3'h2: t = ~eCcr.c;
		3'h3: t = ~eCcr.z;
		3'h4: t = ~eCcr.h;
		3'h5: t = ~eCcr.n;
		3'h6: t = ~intMask;
		default: t = ~irqPin;
		endcase
		return t ^ cc[0];
	endfunction

	task automatic rmModel(input logic [3:0] sub, input logic [7:0] m, output logic [7:0] r);
		logic [8:0] w;
		logic cin;
		cin = (sub == 4'h1 || sub == 4'h3) ? eCcr.c : 1'b0;
		w = 9'h000;
		r = 8'h00;
		case (sub)
		4'h0, 4'h1: w = {1'b0, eAcc} + {1'b0, m} + {8'h00, cin};
		4'h2, 4'h3, 4'h8: w = {1'b0, eAcc} - {1'b0, m} - {8'h00, cin};
		4'h9: w = {1'b0, eIdx} - {1'b0, m};
		4'h4, 4'h7: r = eAcc & m;
		4'h5: r = eAcc | m;
		4'h6: r = eAcc ^ m;
		4'hA, 4'hB: r = m;
		4'hC: r = eAcc;
		default: r = eIdx;
		endcase
		if (sub <= 4'h3 || sub == 4'h8 || sub == 4'h9)
		begin
			r = w[7:0];
			eCcr.c = w[8];
		end
		if (sub <= 4'h1)
			eCcr.h = ({1'b0, eAcc[3:0]} + {1'b0, m[3:0]} + {4'h0, cin}) > 5'h0F;
		if (sub <= 4'h6 || sub == 4'hA)
			eAcc = r;
		if (sub == 4'hB)
			eIdx = r;
		eCcr.n = r[7];
		eCcr.z = (r == 8'h00);
	endtask

	initial
	begin
		logic [7:0] aa;
		logic [7:0] m;
		logic [7:0] off;
		logic [7:0] r;
		logic [15:0] tgt;
		logic [3:0] sub;
		int k;
		miscompares = 0;
		nTests = 0;
		resetn = 1'b0;
		irqPin = 1'b0;
		intMask = 1'b0;
		void'($urandom(32'hb8a4_87cf));
		rstExpect();
		repeat (2) @(posedge mclk);
		#DLY;
		cmpAll();
		resetn = 1'b1;
		for (int i = 0; i < 600; i++)
		begin
			if (i == 300)
			begin
				resetn = 1'b0;
				@(posedge mclk);
				#DLY;
				rstExpect();
				cmpAll();
				resetn = 1'b1;
			end
			irqPin = 1'($urandom);
			intMask = 1'($urandom);
			aa = 8'($urandom);
			m = 8'($urandom);
			off = randOff();
			sub = 4'($urandom_range(0, 13));
			tgt = {2'b01, 14'($urandom)};
			k = $urandom_range(0, 11);
			// Keeps code clear of page 0, where data and stack live
			if (ePc < 16'h2000 || ePc > 16'hDFFF)
				k = 8;
			put(ePc + 16'h0001, aa);
			put(ePc + 16'h0002, off);
			put({8'h00, aa}, m);
			case (k)
			0, 1, 2, 3:
			begin
				put(ePc, {cmbo_pkg::OPG_REG_MEM, sub});
				rmModel(sub, m, r);
				ePc = ePc + 16'h0002;
				runChk(3);
				chkByte(memModel.cells[{8'h00, aa}], (sub >= 4'hC) ? r : m, "mem");
			end
			4:
			begin
				put(ePc, cmbo_pkg::OP_MULTIPLY);
				{eIdx, eAcc} = eIdx * eAcc;
				eCcr.h = 1'b0;
				eCcr.c = 1'b0;
				ePc = ePc + 16'h0001;
				runChk(2);
			end
			5, 6:
			begin
				put(ePc, {cmbo_pkg::OPG_REL_BRANCH, sub[3:0] ^ {2'b00, aa[1:0]}});
				put(ePc + 16'h0001, off);
				ePc = relTaken(sub ^ {2'b00, aa[1:0]}) ? rel(ePc + 16'h0002, off)
					: ePc + 16'h0002;
				runChk(2);
			end
			7:
			begin
				// Polarity drawn apart from the bit number so all sixteen opcodes occur
				put(ePc, {cmbo_pkg::OPG_BIT_BRANCH, sub[2:0], tgt[0]});
				eCcr.c = m[sub[2:0]];
				ePc = (m[sub[2:0]] ^ tgt[0]) ? rel(ePc + 16'h0003, off) : ePc + 16'h0003;
				runChk(4);
			end
			8, 9:
			begin
				put(ePc, (k == 8) ? cmbo_pkg::OP_UNCOND_JUMP : cmbo_pkg::OP_JUMP_SUB);
				put(ePc + 16'h0001, tgt[15:8]);
				put(ePc + 16'h0002, tgt[7:0]);
				r = ePc[7:0];
				aa = ePc[15:8];
				ePc = tgt;
				runChk(k == 8 ? 3 : 5);
				if (k == 9)
					pushChk({aa, r} + 16'h0003);
			end
			10:
			begin
				put(ePc, cmbo_pkg::OP_BRANCH_SUB);
				put(ePc + 16'h0001, off);
				tgt = ePc + 16'h0002;
				ePc = rel(tgt, off);
				runChk(4);
				pushChk(tgt);
			end
			default:
			begin
				put(ePc, 8'h50);
				ePc = ePc + 16'h0001;
				runChk(2);
			end
			endcase
		end
		tallyAndFinish();
	end

	initial
	begin
		#200000;
		fail("watchdog expired");
		tallyAndFinish();
	end
endmodule
